//--- sim/display_status_readback_test.sv
`timescale 1ns/1ps
module display_status_readback_test;
    import status_readback_pkg::*;
    logic        clk_sys = 1'h0;
    logic        link_clk = 1'h0;
    logic        rstn = 1'h0;
    logic        sw_reset = 1'h0;
    logic        ce = 1'h1;
    logic        cmd_valid = 1'h0;
    logic        cmd_dsi = 1'h0;
    logic        cmd_wr = 1'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [6:0]  flags = 7'h7F;
    logic [2:0]  vfmt = 3'h5;
    logic [2:0]  cfmt = 3'h5;
    logic [6:0]  pat [3] = '{7'h55, 7'h2A, 7'h7F};
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        sm_clr;
    logic [7:0]  err_cnt;
    logic        hv;
    logic        he;
    int          num_errors = 0;
    int          total_checks = 0;

    initial forever #5 clk_sys = ~clk_sys;
    initial #7 forever #15 link_clk = ~link_clk;

    display_status_readback display_status_readback_inst
    (
        .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .LINK_CLK(link_clk),
        .LINK_HDR_VALID(hv), .LINK_HDR_PARITY_ERR(he), .SW_RESET(sw_reset),
        .CMD_VALID(cmd_valid), .CMD_FROM_DSI(cmd_dsi), .CMD_WRITE(cmd_wr),
        .CMD_ADDR(cmd_addr), .BOOSTER_ON(flags[6]), .IDLE_MODE(flags[5]),
        .AWAKE(flags[4]), .FULL_DISPLAY(flags[3]), .COLOR_BGR(flags[2]),
        .HORIZ_MIRROR(flags[1]), .VERT_MIRROR(flags[0]), .VIDEO_FORMAT(vfmt),
        .CONTROL_FORMAT(cfmt), .RD_VALID(rd_valid), .RD_DATA(rd_data),
        .SIGNAL_MODE_CLR(sm_clr), .ERROR_COUNT(err_cnt)
    );

    link_header_source hdr_src
    (
        .link_clk(link_clk), .hdr_valid(hv), .hdr_err(he)
    );

    task automatic tally_and_finish();
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Mode bits: software reset first, write, answer expected, from DSI
    task automatic cmd(input logic [15:0] a, input logic [3:0] m,
                       input logic [7:0] e);
        @(posedge clk_sys);
        if (m[3])
        begin
            sw_reset <= 1'h1;
            @(posedge clk_sys);
            sw_reset <= 1'h0;
        end
        cmd_valid <= 1'h1;
        cmd_addr <= a;
        cmd_wr <= m[2];
        cmd_dsi <= m[0];
        @(posedge clk_sys);
        cmd_valid <= 1'h0;
        #1;
        chk({7'h00, rd_valid}, {7'h00, m[1]});
        if (m[1])
            chk(rd_data, e);
    endtask

    task automatic wait_cnt(input logic [7:0] e);
        int i;
        repeat (8) @(posedge clk_sys);
        for (i = 0; i < 500 && err_cnt !== e; i++)
            @(negedge clk_sys);
        if (i == 500)
        begin
            num_errors++;
            tally_and_finish();
        end
        else
            chk(err_cnt, e);
    endtask

    initial
    begin
        logic [3:0] m;
        logic [7:0] pw;
        logic [7:0] ob;
        logic [7:0] px;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'h1;
        cmd_valid <= 1'h1;
        cmd_dsi <= 1'h1;
        cmd_addr <= ADDR_POWER_MODE;
        @(posedge clk_sys);
        cmd_valid <= 1'h0;
        #1;
        chk(rd_data, 8'h08);
        foreach (pat[k])
        begin
            m = {3'h1, k[0]};
            pw = {pat[k][6:5], 1'h0, pat[k][4:3], 3'h0};
            ob = {4'h0, pat[k][2], 1'h0, pat[k][1:0]};
            px = {1'h0, 3'h5 + 3'(k), 1'h0, 3'h7 - 3'(k)};
            @(posedge clk_sys);
            flags <= pat[k];
            vfmt <= 3'h5 + 3'(k);
            cfmt <= 3'h7 - 3'(k);
            cmd(ADDR_POWER_MODE, m, pw);
            cmd(ADDR_ORIENTATION, m, ob);
            cmd(ADDR_PIXEL_FORMAT, m, px);
        end
        cmd(ADDR_POWER_MODE, 4'h5, 8'h00);
        cmd(16'h0D00, 4'h1, 8'h00);
        hdr_src.send(3, 1'h1);
        hdr_src.send(2, 1'h0);
        wait_cnt(8'h03);
        cmd(ADDR_LINK_ERROR_COUNT, 4'h0, 8'h00);
        cmd(ADDR_LINK_ERROR_COUNT, 4'h5, 8'h00);
        chk(err_cnt, 8'h03);
        cmd(ADDR_LINK_ERROR_COUNT, 4'h3, 8'h03);
        chk({7'h00, sm_clr}, 8'h01);
        chk(err_cnt, 8'h00);
        hdr_src.send(130, 1'h1);
        wait_cnt(8'hFF);
        cmd(ADDR_LINK_ERROR_COUNT, 4'h3, 8'hFF);
        hdr_src.send(2, 1'h1);
        wait_cnt(8'h02);
        cmd(ADDR_POWER_MODE, 4'hB, 8'h08);
        chk(err_cnt, 8'h00);
        cmd(ADDR_ORIENTATION, 4'hA, 8'h00);
        cmd(ADDR_PIXEL_FORMAT, 4'hB, 8'h70);
        @(posedge clk_sys);
        ce <= 1'h0;
        cmd(ADDR_POWER_MODE, 4'h1, 8'h00);
        chk(rd_data, 8'h70);
        @(posedge clk_sys);
        ce <= 1'h1;
        tally_and_finish();
    end
endmodule

//--- sim/link_header_source.sv
`timescale 1ns/1ps
module link_header_source
(
    input  wire logic link_clk,
    output logic      hdr_valid,
    output logic      hdr_err
);
    initial
    begin
        hdr_valid = 1'h0;
        hdr_err = 1'h1;
    end
    task automatic send(input int n, input logic bad);
        repeat (n)
        begin
            @(posedge link_clk);
            hdr_valid <= 1'h1;
            hdr_err <= bad;
            @(posedge link_clk);
            hdr_valid <= 1'h0;
            hdr_err <= ~bad;
        end
    endtask
endmodule

//--- sim/status_readback_monitor.sv
`timescale 1ns/1ps
module status_readback_monitor
    import status_readback_pkg::*;
#(parameter int COUNT_W = ERR_COUNT_W)
(
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic        CE,
    input wire logic        SW_RESET,
    input wire logic        CMD_VALID,
    input wire logic        CMD_FROM_DSI,
    input wire logic        CMD_WRITE,
    input wire logic [15:0] CMD_ADDR,
    input wire logic        RD_VALID,
    input wire logic [7:0]  RD_DATA,
    input wire logic        SIGNAL_MODE_CLR,
    input wire logic [7:0]  ERROR_COUNT
);
    logic rd_tk;
    logic err_tk;
    logic map_tk;
    assign rd_tk = CE && CMD_VALID && !CMD_WRITE;
    assign err_tk = rd_tk && CMD_FROM_DSI
        && CMD_ADDR == ADDR_LINK_ERROR_COUNT;
    assign map_tk = rd_tk && CMD_ADDR inside
        {ADDR_POWER_MODE, ADDR_ORIENTATION, ADDR_PIXEL_FORMAT};
    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    read_answer_a: assert property (
        (map_tk || err_tk) ##1 CE |-> RD_VALID) else $error("no answer");
    dsi_only_a: assert property (
        rd_tk && !CMD_FROM_DSI && CMD_ADDR == ADDR_LINK_ERROR_COUNT ##1 CE
        |-> !RD_VALID && !SIGNAL_MODE_CLR) else $error("count off link");
    write_ignored_a: assert property (
        CE && CMD_VALID && CMD_WRITE ##1 CE |-> !RD_VALID)
        else $error("write answered");
    unmapped_read_a: assert property (
        rd_tk && !map_tk && !err_tk ##1 CE |-> !RD_VALID)
        else $error("unmapped answered");
    err_value_a: assert property (
        err_tk ##1 CE |-> RD_DATA == $past(ERROR_COUNT))
        else $error("wrong count byte");
    err_clear_a: assert property (
        err_tk ##1 CE |-> SIGNAL_MODE_CLR && ERROR_COUNT <= 8'h01)
        else $error("count not cleared");
    overflow_flag_a: assert property (
        ERROR_COUNT[7] |-> &ERROR_COUNT[COUNT_W-1:0])
        else $error("overflow without full count");
    sw_clear_a: assert property (
        CE && SW_RESET |=> ERROR_COUNT == RST_LINK_ERROR_COUNT)
        else $error("count kept over reset");
    err_cov: cover property (err_tk ##1 RD_VALID);
    wr_cov: cover property (CE && CMD_VALID && CMD_WRITE);
    ovf_cov: cover property (ERROR_COUNT[7]);
endmodule

bind display_status_readback status_readback_monitor
    #(.COUNT_W(COUNT_W)) status_readback_monitor_inst
(
    .CLK_SYS, .RSTN, .CE, .SW_RESET, .CMD_VALID, .CMD_FROM_DSI, .CMD_WRITE,
    .CMD_ADDR, .RD_VALID, .RD_DATA, .SIGNAL_MODE_CLR, .ERROR_COUNT
);

//--- src/display_status_readback.sv
`timescale 1ns/1ps
// Overview of operation
// - Error count read answers only over DSI
// - Low seven bits count link parity errors
// - Bit 7 flags count overflow
// - Finished count read clears count, signal bit
// - Power bit 7 shows booster running
// - Power bit 6 shows idle mode
// - Power bit 4 shows out of sleep
// - Power bit 3 shows full display
// - Power readback defaults to 08h
// - Orientation bit 3 is BGR order
// - Orientation bit 1 horizontal mirror
// - Orientation bit 0 vertical mirror
// - Orientation reserved zero, default 00h
// - Pixel bits 6-4 video port format
// - Pixel bits 2-0 control port format
// - Pixel bits 7,3 zero, default 70h
module display_status_readback
    import status_readback_pkg::*;
#(
    parameter int COUNT_W = ERR_COUNT_W
)
(
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        CE,
    input  wire logic        LINK_CLK,
    input  wire logic        LINK_HDR_VALID,
    input  wire logic        LINK_HDR_PARITY_ERR,
    input  wire logic        SW_RESET,
    input  wire logic        CMD_VALID,
    input  wire logic        CMD_FROM_DSI,
    input  wire logic        CMD_WRITE,
    input  wire logic [15:0] CMD_ADDR,
    input  wire logic        BOOSTER_ON,
    input  wire logic        IDLE_MODE,
    input  wire logic        AWAKE,
    input  wire logic        FULL_DISPLAY,
    input  wire logic        COLOR_BGR,
    input  wire logic        HORIZ_MIRROR,
    input  wire logic        VERT_MIRROR,
    input  wire logic [2:0]  VIDEO_FORMAT,
    input  wire logic [2:0]  CONTROL_FORMAT,
    output logic             RD_VALID,
    output logic [7:0]       RD_DATA,
    output logic             SIGNAL_MODE_CLR,
    output logic [7:0]       ERROR_COUNT
);

    // Error byte layout holds exactly seven count bits
    if (COUNT_W != ERR_COUNT_W)
    begin
        $error("COUNT_W must match the error byte layout");
    end

    link_event_if ev ();

    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic               overflow_reg;
    logic               overflow_next;
    logic [7:0]         power_reg;
    logic [7:0]         orient_reg;
    logic [7:0]         pixel_reg;
    logic               rd_valid_reg;
    logic [7:0]         rd_data_reg;
    logic               sig_clr_reg;
    logic [7:0]         err_out_reg;
    readback_sel_t      sel;
    logic               take_read;
    logic               clear_count;
    logic               soft_rst;

    // Map a command address to a readback
    function automatic readback_sel_t decode_addr
    (
        input logic [15:0] addr,
        input logic        from_dsi
    );
        readback_sel_t s;
        s = SEL_NONE;
        unique case (addr)
            ADDR_LINK_ERROR_COUNT:
            begin
                if (from_dsi)
                    s = SEL_LINK_ERROR_COUNT;
            end
            ADDR_POWER_MODE:
                s = SEL_POWER_MODE;
            ADDR_ORIENTATION:
                s = SEL_ORIENTATION;
            ADDR_PIXEL_FORMAT:
                s = SEL_PIXEL_FORMAT;
            default:
                s = SEL_NONE;
        endcase
        return s;
    endfunction

    // Assemble the error byte
    function automatic logic [7:0] error_byte
    (
        input logic [COUNT_W-1:0] cnt,
        input logic               ovf
    );
        logic [7:0] b;
        b = 8'h00;
        b[COUNT_W-1:0] = cnt;
        b[POS_OVERFLOW] = ovf;
        return b;
    endfunction

    // Pack the power and operation mode flags
    function automatic logic [7:0] power_byte
    (
        input logic booster,
        input logic idle,
        input logic awake,
        input logic full
    );
        logic [7:0] b;
        b = 8'h00;
        b[POS_BOOSTER_ON] = booster;
        b[POS_IDLE_MODE] = idle;
        b[POS_AWAKE] = awake;
        b[POS_FULL_DISPLAY] = full;
        return b;
    endfunction

    // Pack the orientation flags, reserved bits zero
    function automatic logic [7:0] orient_byte
    (
        input logic bgr,
        input logic hmirror,
        input logic vmirror
    );
        logic [7:0] b;
        b = 8'h00;
        b[POS_COLOR_BGR] = bgr;
        b[POS_HORIZ_MIRROR] = hmirror;
        b[POS_VERT_MIRROR] = vmirror;
        return b;
    endfunction

    // Pack the two interface pixel formats
    function automatic logic [7:0] pixel_byte
    (
        input logic [FMT_W-1:0] video,
        input logic [FMT_W-1:0] control
    );
        logic [7:0] b;
        b = 8'h00;
        b[POS_VIDEO_FMT_LSB +: FMT_W] = video;
        b[POS_CONTROL_FMT_LSB +: FMT_W] = control;
        return b;
    endfunction

    link_parity_monitor u_monitor
    (
        .link_clk       (LINK_CLK),
        .rstn           (RSTN),
        .hdr_valid      (LINK_HDR_VALID),
        .hdr_parity_err (LINK_HDR_PARITY_ERR),
        .ev             (ev.link_side)
    );

    event_toggle_sync u_sync
    (
        .clk  (CLK_SYS),
        .rstn (RSTN),
        .ce   (CE),
        .ev   (ev.sys_side)
    );

    assign soft_rst = SW_RESET;
    assign sel = decode_addr(CMD_ADDR, CMD_FROM_DSI);

    assign take_read = CE && CMD_VALID && !CMD_WRITE && (sel != SEL_NONE);

    // clear on the finished count read
    assign clear_count = take_read && (sel == SEL_LINK_ERROR_COUNT);

    // Counter next value, a new error beats the clear
    always_comb
    begin
        count_next = count_reg;
        overflow_next = overflow_reg;
        if (clear_count)
        begin
            count_next = '0;
            overflow_next = 1'b0;
        end
        if (ev.event_pulse)
        begin
            if (clear_count)
                count_next = COUNT_W'(1);
            else if (count_reg == {COUNT_W{1'b1}})
                overflow_next = 1'b1;
            else
                count_next = count_reg + COUNT_W'(1);
        end
    end

    // Error counter
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || (CE && soft_rst))
        begin
            count_reg <= RST_LINK_ERROR_COUNT[COUNT_W-1:0];
            overflow_reg <= RST_LINK_ERROR_COUNT[POS_OVERFLOW];
        end
        else if (CE)
        begin
            count_reg <= count_next;
            overflow_reg <= overflow_next;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || (CE && soft_rst))
            power_reg <= RST_POWER_MODE;
        else if (CE)
            power_reg <= power_byte(BOOSTER_ON, IDLE_MODE, AWAKE, FULL_DISPLAY);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || (CE && soft_rst))
            orient_reg <= RST_ORIENTATION;
        else if (CE)
            orient_reg <= orient_byte(COLOR_BGR, HORIZ_MIRROR, VERT_MIRROR);
    end

    // pixel format default, bits 7 and 3 zero
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || (CE && soft_rst))
            pixel_reg <= RST_PIXEL_FORMAT;
        else if (CE)
            pixel_reg <= pixel_byte(VIDEO_FORMAT, CONTROL_FORMAT);
    end

    // Read answer, one cycle after the command
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= 8'h00;
        end
        else if (CE)
        begin
            rd_valid_reg <= take_read;
            if (take_read)
            begin
                unique case (sel)
                    SEL_LINK_ERROR_COUNT:
                        rd_data_reg <= error_byte(count_reg, overflow_reg);
                    SEL_POWER_MODE:
                        rd_data_reg <= power_reg;
                    SEL_ORIENTATION:
                        rd_data_reg <= orient_reg;
                    SEL_PIXEL_FORMAT:
                        rd_data_reg <= pixel_reg;
                    SEL_NONE:
                        rd_data_reg <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            sig_clr_reg <= 1'b0;
        else if (CE)
            sig_clr_reg <= clear_count;
    end

    // Live copy of the error byte
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN || (CE && soft_rst))
            err_out_reg <= RST_LINK_ERROR_COUNT;
        else if (CE)
            err_out_reg <= error_byte(count_next, overflow_next);
    end

    assign RD_VALID        = rd_valid_reg;
    assign RD_DATA         = rd_data_reg;
    assign SIGNAL_MODE_CLR = sig_clr_reg;
    assign ERROR_COUNT     = err_out_reg;

endmodule

//--- src/event_toggle_sync.sv
`timescale 1ns/1ps
module event_toggle_sync
(
    input  wire logic  clk,
    input  wire logic  rstn,
    input  wire logic  ce,
    link_event_if.sys_side ev
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Two-stage synchroniser then edge detect
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else if (ce)
        begin
            meta_reg <= ev.event_toggle;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign ev.event_pulse = ce && (sync_reg != last_reg);

endmodule

//--- src/link_event_if.sv
`timescale 1ns/1ps
interface link_event_if;
    logic event_toggle;
    logic event_pulse;

    modport link_side
    (
        output event_toggle
    );
    modport sys_side
    (
        input  event_toggle,
        output event_pulse
    );
    modport consumer
    (
        input event_pulse
    );
endinterface

//--- src/link_parity_monitor.sv
`timescale 1ns/1ps
module link_parity_monitor
(
    input  wire logic   link_clk,
    input  wire logic   rstn,
    input  wire logic   hdr_valid,
    input  wire logic   hdr_parity_err,
    link_event_if.link_side ev
);

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic toggle_reg;

    // Reset brought into the link domain
    always_ff @(posedge link_clk)
    begin
        rst_meta_reg <= rstn;
        rst_sync_reg <= rst_meta_reg;
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_sync_reg)
            toggle_reg <= 1'b0;
        else if (hdr_valid && hdr_parity_err)
            toggle_reg <= ~toggle_reg;
    end

    assign ev.event_toggle = toggle_reg;

endmodule

//--- src/status_readback_pkg.sv
package status_readback_pkg;

    // Command addresses on the 16-bit control interfaces
    localparam logic [15:0] ADDR_LINK_ERROR_COUNT = 16'h0500;
    localparam logic [15:0] ADDR_POWER_MODE       = 16'h0A00;
    localparam logic [15:0] ADDR_ORIENTATION      = 16'h0B00;
    localparam logic [15:0] ADDR_PIXEL_FORMAT     = 16'h0C00;

    // Reset values of the readbacks
    localparam logic [7:0] RST_LINK_ERROR_COUNT = 8'h00;
    localparam logic [7:0] RST_POWER_MODE       = 8'h08;
    localparam logic [7:0] RST_ORIENTATION      = 8'h00;
    localparam logic [7:0] RST_PIXEL_FORMAT     = 8'h70;

    // Power mode field positions
    localparam int POS_BOOSTER_ON   = 7;
    localparam int POS_IDLE_MODE    = 6;
    localparam int POS_AWAKE        = 4;
    localparam int POS_FULL_DISPLAY = 3;

    // Orientation field positions
    localparam int POS_COLOR_BGR    = 3;
    localparam int POS_HORIZ_MIRROR = 1;
    localparam int POS_VERT_MIRROR  = 0;

    // Pixel format field positions
    localparam int POS_VIDEO_FMT_LSB   = 4;
    localparam int POS_CONTROL_FMT_LSB = 0;
    localparam int FMT_W               = 3;

    // Pixel format encodings
    localparam logic [2:0] FMT_16BPP = 3'h5;
    localparam logic [2:0] FMT_18BPP = 3'h6;
    localparam logic [2:0] FMT_24BPP = 3'h7;

    // Error count layout
    localparam int ERR_COUNT_W  = 7;
    localparam int POS_OVERFLOW = 7;

    typedef enum {
        SEL_NONE,
        SEL_LINK_ERROR_COUNT,
        SEL_POWER_MODE,
        SEL_ORIENTATION,
        SEL_PIXEL_FORMAT
    } readback_sel_t;

endpackage
